/* hdl/cpm_pkg.sv */
// Purpose: constants for the codec power-mode and autocalibration sequencer
// Assumes: 20 MHz system clock, 48 kHz nominal sample rate
// Notes:   all delays are counted in system clock cycles or sample ticks
package cpm_pkg;
  localparam int CLK_HZ          = 20_000_000;
  localparam int SAMPLE_HZ       = 48_000;
  localparam int SAMPLE_DIV      = CLK_HZ / SAMPLE_HZ;
  localparam int INIT_MS         = 512;
  localparam int INIT_CYC        = (CLK_HZ / 1000) * INIT_MS;
  localparam int TPD_ENTRY_US    = 3000;
  localparam int TPD_CYC         = (CLK_HZ / 1_000_000) * TPD_ENTRY_US;
  localparam int RESTORE_SAMPLES = 128;
  localparam int CAL_SAMPLES     = 384;
  localparam int CNT_W           = 24;
  // register byte offsets
  localparam logic [3:0] OFS_CTRL   = 4'h0;
  localparam logic [3:0] OFS_PWRDN  = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;
  // control register fields
  localparam int CTRL_MCE  = 0;
  localparam int CTRL_AUTOCALIBRATE_ENABLE = 1;
  localparam int CTRL_TPD  = 2;
  // power-down register fields
  localparam int PD_CAP = 0;
  localparam int PD_PLY = 1;
  localparam int PD_MIX = 2;
  // reset values
  localparam logic [2:0] CTRL_RST  = 3'h1;
  localparam logic [2:0] PWRDN_RST = 3'h0;
  localparam logic [7:0] INIT_READ = 8'h80;
  // software power mode one-hot positions
  localparam int M_TOT = 0;
  localparam int M_STB = 1;
  localparam int M_MIX = 2;
  localparam int M_MXO = 3;
  localparam int M_CAP = 4;
  localparam int M_PLY = 5;
  typedef enum logic [5:0] {
    ST_INIT    = 6'b000001,
    ST_RUN     = 6'b000010,
    ST_TPD_ENT = 6'b000100,
    ST_TPD     = 6'b001000,
    ST_SWPD    = 6'b010000,
    ST_RESTORE = 6'b100000
  } cpm_state_t;
endpackage

/* hdl/cpm_sequencer.sv */
// Purpose: power-mode control and autocalibration sequencing over AXI4-Lite
// Assumes: pins synchronous to CLK_SYS; CE low freezes all state except the two reset release flops
// Notes:   long counts are parameters so simulation can shorten them
`timescale 1ns/1ps
`default_nettype none
module cpm_sequencer
  import cpm_pkg::*;
#(
  parameter int INIT_CYCLES = cpm_pkg::INIT_CYC,
  parameter int TPD_CYCLES  = cpm_pkg::TPD_CYC,
  parameter int SAMPLE_CYC  = cpm_pkg::SAMPLE_DIV
) (
  input  wire logic        CLK_SYS,            // system clock
  input  wire logic        RESETN,             // async reset, active low
  input  wire logic        CE,                 // clock enable
  input  wire logic [3:0]  S_AXI_AWADDR,       // write address
  input  wire logic        S_AXI_AWVALID,      // write address valid
  output logic             S_AXI_AWREADY,      // write address ready
  input  wire logic [31:0] S_AXI_WDATA,        // write data
  input  wire logic [3:0]  S_AXI_WSTRB,        // write strobes
  input  wire logic        S_AXI_WVALID,       // write data valid
  output logic             S_AXI_WREADY,       // write data ready
  output logic [1:0]       S_AXI_BRESP,        // write response
  output logic             S_AXI_BVALID,       // write response valid
  input  wire logic        S_AXI_BREADY,       // write response ready
  input  wire logic [3:0]  S_AXI_ARADDR,       // read address
  input  wire logic        S_AXI_ARVALID,      // read address valid
  output logic             S_AXI_ARREADY,      // read address ready
  output logic [31:0]      S_AXI_RDATA,        // read data
  output logic [1:0]       S_AXI_RRESP,        // read response
  output logic             S_AXI_RVALID,       // read data valid
  input  wire logic        S_AXI_RREADY,       // read data ready
  input  wire logic        HW_PWRDOWN_N,       // hardware power-down pin
  input  wire logic        HW_RESET_N,         // hardware reset pin
  input  wire logic [1:0]  DMA_REQ_IN,         // {playback, capture} requests
  output logic [1:0]       DMA_REQ_OUT,        // gated requests
  output logic             CAPTURE_EN,         // capture engine and gain stage
  output logic             PLAYBACK_EN,        // playback engine
  output logic             MIXER_EN,           // analog mixer
  output logic             REFERENCE_EN,       // voltage reference
  output logic             OUTPUT_MUTE,        // outputs muted
  output logic             FLUSH_CAPTURE,      // flush capture data and fifo
  output logic             FLUSH_PLAYBACK,     // flush playback data and fifo
  output logic             CAPTURE_VALID,      // captured data meaningful
  output logic             PLAYBACK_ACCEPT,    // playback input taken
  output logic             CAL_BUSY,           // calibration in progress
  output logic             OFFSET_STORE        // pulse: store new offsets
);
  import cpm_pkg::*;

  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  // priority decode of software power bits
  function automatic logic [5:0] sw_mode(input logic tot, input logic [2:0] pd);
    logic [5:0] m;
    m = 6'h00;
    if (tot) m[M_TOT] = 1'b1;
    else if (pd[PD_CAP] && pd[PD_MIX]) m[M_STB] = 1'b1;
    else if (pd[PD_MIX]) m[M_MIX] = 1'b1;
    else if (pd[PD_CAP] && pd[PD_PLY]) m[M_MXO] = 1'b1;
    else if (pd[PD_CAP]) m[M_CAP] = 1'b1;
    else if (pd[PD_PLY]) m[M_PLY] = 1'b1;
    return m;
  endfunction

  // reset release through two flops
  logic rst_meta_q;
  logic rst_n;
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  cpm_state_t        st_q;
  logic [CNT_W-1:0]  cnt_q;
  logic [8:0]        div_q;
  logic              tick;
  logic              hw_off;
  logic [2:0]        ctrl_q;
  logic [2:0]        pwrdn_q;
  logic [5:0]        mode_q;
  logic              first_q;
  logic              cal_q;
  logic [8:0]        cal_cnt_q;
  logic              mce_fall;
  logic              in_init;
  logic              aw_q;
  logic              w_q;
  logic [3:0]        awaddr_q;
  logic [31:0]       wdata_q;
  logic              wstrb0_q;
  logic              wr_go;
  logic              ar_hs;
  logic [31:0]       status;

  assign hw_off  = !HW_PWRDOWN_N || !HW_RESET_N;
  assign in_init = (st_q == ST_INIT);
  assign tick    = (div_q == 9'(SAMPLE_CYC - 1));
  assign wr_go   = aw_q && w_q && !S_AXI_BVALID;
  assign ar_hs   = S_AXI_ARVALID && S_AXI_ARREADY;

  // sample period divider, free running
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 9'h000;
    end else if (CE) begin
      div_q <= tick ? 9'h000 : div_q + 9'h001;
    end
  end

  // write address and data taken in either order
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      aw_q          <= 1'b0;
      w_q           <= 1'b0;
      awaddr_q      <= 4'h0;
      wdata_q       <= 32'h0000_0000;
      wstrb0_q      <= 1'b0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= RESP_OK;
    end else if (CE) begin
      S_AXI_AWREADY <= !aw_q && !S_AXI_AWREADY && S_AXI_AWVALID;
      S_AXI_WREADY  <= !w_q && !S_AXI_WREADY && S_AXI_WVALID;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_q     <= 1'b1;
        awaddr_q <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_q      <= 1'b1;
        wdata_q  <= S_AXI_WDATA;
        // strobe belongs to the data beat; the master may drop it after the handshake
        wstrb0_q <= S_AXI_WSTRB[0];
      end
      if (wr_go) begin
        aw_q         <= 1'b0;
        w_q          <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= (awaddr_q[3:2] == 2'h3) ? RESP_ERR : RESP_OK;
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // status word shows the sequencer's own state
  assign status = {22'h0, mode_q, st_q == ST_SWPD, st_q == ST_TPD,
                   st_q == ST_RESTORE, cal_q};

  // read channel; initialising reads always give the busy marker
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0000_0000;
      S_AXI_RRESP   <= RESP_OK;
    end else if (CE) begin
      S_AXI_ARREADY <= !S_AXI_RVALID && !S_AXI_ARREADY && S_AXI_ARVALID;
      if (ar_hs) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP  <= RESP_OK;
        if (in_init) begin
          S_AXI_RDATA <= {24'h0, INIT_READ};
        end else begin
          unique case (S_AXI_ARADDR)
            OFS_CTRL:   S_AXI_RDATA <= {29'h0, ctrl_q};
            OFS_PWRDN:  S_AXI_RDATA <= {29'h0, pwrdn_q};
            OFS_STATUS: S_AXI_RDATA <= status;
            default: begin
              S_AXI_RDATA <= 32'h0000_0000;
              S_AXI_RRESP <= RESP_ERR;
            end
          endcase
        end
      end else if (S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  // control registers; defaults come back on every initialisation
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q  <= CTRL_RST;
      pwrdn_q <= PWRDN_RST;
    end else if (CE) begin
      if (in_init) begin
        ctrl_q  <= CTRL_RST;
        pwrdn_q <= PWRDN_RST;
      end else if (wr_go && wstrb0_q) begin
        if (awaddr_q == OFS_CTRL) begin
          ctrl_q[CTRL_MCE]  <= wdata_q[CTRL_MCE];
          ctrl_q[CTRL_AUTOCALIBRATE_ENABLE] <= wdata_q[CTRL_AUTOCALIBRATE_ENABLE];
          // set only from mode change; clearing always allowed
          if (ctrl_q[CTRL_MCE] || !wdata_q[CTRL_TPD])
            ctrl_q[CTRL_TPD] <= wdata_q[CTRL_TPD];
        end
        if (awaddr_q == OFS_PWRDN)
          pwrdn_q <= wdata_q[2:0];
      end
    end
  end

  assign mce_fall = wr_go && wstrb0_q && !in_init && awaddr_q == OFS_CTRL
                    && ctrl_q[CTRL_MCE] && !wdata_q[CTRL_MCE];

  // power sequencing state machine
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      st_q   <= ST_INIT;
      cnt_q  <= '0;
      mode_q <= 6'h00;
    end else if (CE) begin
      if (hw_off) begin
        st_q   <= ST_INIT;
        cnt_q  <= '0;
        mode_q <= 6'h00;
      end else begin
        unique case (st_q)
          ST_INIT: begin
            mode_q <= 6'h00;
            cnt_q  <= cnt_q + 1'b1;
            if (cnt_q == CNT_W'(INIT_CYCLES - 1)) begin
              st_q  <= ST_RUN;
              cnt_q <= '0;
            end
          end
          ST_RUN: begin
            if (ctrl_q[CTRL_TPD]) begin
              st_q   <= ST_TPD_ENT;
              mode_q <= sw_mode(1'b1, pwrdn_q);
              cnt_q  <= '0;
            end else if (|pwrdn_q && tick) begin
              st_q   <= ST_SWPD;
              mode_q <= sw_mode(1'b0, pwrdn_q);
            end
          end
          ST_TPD_ENT: begin
            cnt_q <= cnt_q + 1'b1;
            if (cnt_q == CNT_W'(TPD_CYCLES - 1))
              st_q <= ST_TPD;
          end
          ST_TPD: begin
            if (!ctrl_q[CTRL_TPD]) begin
              st_q  <= ST_INIT;
              cnt_q <= '0;
            end
          end
          ST_SWPD: begin
            if (ctrl_q[CTRL_TPD]) begin
              st_q   <= ST_TPD_ENT;
              mode_q <= sw_mode(1'b1, pwrdn_q);
              cnt_q  <= '0;
            end else if (tick) begin
              if (pwrdn_q == 3'h0) begin
                st_q   <= ST_RESTORE;
                mode_q <= 6'h00;
                cnt_q  <= '0;
              end else begin
                mode_q <= sw_mode(1'b0, pwrdn_q);
              end
            end
          end
          ST_RESTORE: begin
            if (tick) begin
              cnt_q <= cnt_q + 1'b1;
              if (cnt_q == CNT_W'(RESTORE_SAMPLES - 1))
                st_q <= ST_RUN;
            end
          end
          default: st_q <= ST_INIT;
        endcase
      end
    end
  end

  // autocalibration; offsets only rewritten when it actually runs
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      first_q      <= 1'b1;
      cal_q        <= 1'b0;
      cal_cnt_q    <= 9'h000;
      OFFSET_STORE <= 1'b0;
    end else if (CE) begin
      OFFSET_STORE <= 1'b0;
      if (in_init || hw_off) begin
        first_q   <= 1'b1;
        cal_q     <= 1'b0;
        cal_cnt_q <= 9'h000;
      end else if (cal_q) begin
        if (tick) begin
          cal_cnt_q <= cal_cnt_q + 9'h001;
          if (cal_cnt_q == 9'(CAL_SAMPLES - 1)) begin
            cal_q        <= 1'b0;
            OFFSET_STORE <= 1'b1;
          end
        end
      end else if (mce_fall && (first_q || ctrl_q[CTRL_AUTOCALIBRATE_ENABLE])) begin
        cal_q     <= 1'b1;
        cal_cnt_q <= 9'h000;
        first_q   <= 1'b0;
      end
    end
  end

  // engine enables, mute and flushes from state and mode
  logic active;
  logic dead;
  assign active = st_q == ST_RUN || st_q == ST_SWPD || st_q == ST_RESTORE;
  assign dead   = in_init || st_q == ST_TPD_ENT || st_q == ST_TPD;
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      CAPTURE_EN     <= 1'b0;
      PLAYBACK_EN    <= 1'b0;
      MIXER_EN       <= 1'b0;
      REFERENCE_EN   <= 1'b0;
      OUTPUT_MUTE    <= 1'b1;
      FLUSH_CAPTURE  <= 1'b1;
      FLUSH_PLAYBACK <= 1'b1;
    end else if (CE) begin
      CAPTURE_EN     <= active && !(mode_q[M_STB] | mode_q[M_MXO] | mode_q[M_CAP]);
      PLAYBACK_EN    <= active && !(mode_q[M_STB] | mode_q[M_MIX] | mode_q[M_MXO]
                                    | mode_q[M_PLY]);
      MIXER_EN       <= active && !(mode_q[M_STB] | mode_q[M_MIX]);
      REFERENCE_EN   <= !(in_init || st_q == ST_TPD);
      OUTPUT_MUTE    <= !active || st_q == ST_RESTORE || mode_q[M_STB]
                        || mode_q[M_MIX];
      FLUSH_CAPTURE  <= dead || mode_q[M_STB] || mode_q[M_MXO] || mode_q[M_CAP];
      FLUSH_PLAYBACK <= dead || mode_q[M_STB] || mode_q[M_MIX] || mode_q[M_MXO]
                        || mode_q[M_PLY];
    end
  end

  // data gating; requests waiting on calibration are held, not dropped
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      DMA_REQ_OUT     <= 2'h0;
      CAPTURE_VALID   <= 1'b0;
      PLAYBACK_ACCEPT <= 1'b0;
      CAL_BUSY        <= 1'b0;
    end else if (CE) begin
      DMA_REQ_OUT     <= cal_q ? 2'h0 : DMA_REQ_IN & {PLAYBACK_EN, CAPTURE_EN};
      CAPTURE_VALID   <= CAPTURE_EN && !cal_q;
      PLAYBACK_ACCEPT <= PLAYBACK_EN && !cal_q;
      CAL_BUSY        <= cal_q;
    end
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!rst_n || !CE);

  a_tpd_needs_mce: assert property ($rose(st_q == ST_TPD_ENT) |-> $past(ctrl_q[CTRL_TPD]))
    else $error("total power-down entered without request");
  a_init_reads_80: assert property (ar_hs && in_init |=> S_AXI_RDATA == 32'h0000_0080)
    else $error("read during init not 80h");
  a_tpd_all_off: assert property (st_q == ST_TPD |=> !MIXER_EN && !REFERENCE_EN
                                  && FLUSH_CAPTURE && FLUSH_PLAYBACK)
    else $error("total power-down left engines on");
  a_stby_flushes: assert property (st_q == ST_SWPD && mode_q[M_STB]
                                   |=> OUTPUT_MUTE && FLUSH_CAPTURE && FLUSH_PLAYBACK)
    else $error("standby not muted and flushed");
  a_restore_done: assert property (st_q == ST_RESTORE && tick
                                   && cnt_q == CNT_W'(RESTORE_SAMPLES - 1) |=> st_q == ST_RUN)
    else $error("restore length wrong");
  a_first_cal: assert property (mce_fall && first_q && !cal_q && !hw_off |=> cal_q)
    else $error("first mode-change exit did not calibrate");
  a_cal_skip: assert property (mce_fall && !first_q && !ctrl_q[CTRL_AUTOCALIBRATE_ENABLE] && !cal_q
                               |=> !cal_q [*2])
    else $error("calibration ran without enable");
  a_cal_length: assert property ($fell(cal_q) && !$past(in_init || hw_off)
                                 |-> $past(cal_cnt_q) == 9'(CAL_SAMPLES - 1))
    else $error("calibration length wrong");
  a_dma_held: assert property (cal_q |=> DMA_REQ_OUT == 2'h0)
    else $error("transfer started during calibration");
  a_hw_override: assert property (hw_off |=> in_init)
    else $error("hardware pins did not override");
  a_offset_kept: assert property (OFFSET_STORE |-> $past(cal_q))
    else $error("offsets stored without calibration");

  c_cal_run: cover property ($fell(cal_q));
  c_tpd: cover property (st_q == ST_TPD);
  c_swpd: cover property (st_q == ST_SWPD && mode_q[M_MXO]);
  c_restore: cover property ($fell(st_q == ST_RESTORE));
endmodule
`default_nettype wire

/* verification/cpm_host_model.sv */
// Purpose: host software model, an AXI4-Lite master for the sequencer
// Assumes: one write or one read at a time, all changes just after a rising edge
// Notes:   released address and data lines show the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
module cpm_host_model (
  input  wire logic        clk,      // system clock
  output var  logic [3:0]  awaddr,   // write address
  output var  logic        awvalid,  // write address valid
  input  wire logic        awready,  // write address ready
  output var  logic [31:0] wdata,    // write data
  output var  logic [3:0]  wstrb,    // write strobes
  output var  logic        wvalid,   // write data valid
  input  wire logic        wready,   // write data ready
  input  wire logic [1:0]  bresp,    // write response
  input  wire logic        bvalid,   // write response valid
  output var  logic        bready,   // write response ready
  output var  logic [3:0]  araddr,   // read address
  output var  logic        arvalid,  // read address valid
  input  wire logic        arready,  // read address ready
  input  wire logic [31:0] rdata,    // read data
  input  wire logic [1:0]  rresp,    // read response
  input  wire logic        rvalid,   // read data valid
  output var  logic        rready    // read data ready
);
  // idle bus at time zero
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  // address and data offered together, each dropped when taken
  task automatic wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] r);
    @(posedge clk);
    awaddr  <= a;
    wdata   <= v;
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr  <= ~a;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata  <= ~v;
      end
    end while (!(bvalid === 1'b1));
    r = bresp;
    bready <= 1'b0;
  endtask
  // read: address held until taken, rready held until answer sampled
  task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] r);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr  <= ~a;
      end
    end while (!(rvalid === 1'b1));
    v = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* verification/codec_power_modes_autocal_tb_top.sv */
// Purpose: self-checking bench for the power-mode and calibration sequencer
// Assumes: shortened counts: init 40, total power-down entry 20, sample 8 cycles
// Notes:   registers reached only through the host model's bus tasks
`timescale 1ns/1ps
`default_nettype none
module codec_power_modes_autocal_tb_top;
  import cpm_pkg::*;
  localparam int SC = 8;
  localparam int TC = 20;
  logic        clk_sys, resetn, ce, hw_pd_n, hw_rst_n, prev_busy, bad_gate, ofs_seen;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, d;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp, dma_in, dma_out, r;
  logic        cap_en, ply_en, mix_en, ref_en, mute, fl_cap, fl_ply, cap_vld, ply_acc;
  logic        cal_busy, ofs_st;
  logic [10:0] mode_exp [1:7];
  int          num_errors, tests_run, cyc, t0;

  cpm_host_model host (.clk(clk_sys), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  cpm_sequencer #(.INIT_CYCLES(40), .TPD_CYCLES(TC), .SAMPLE_CYC(SC)) dut (
    .CLK_SYS(clk_sys), .RESETN(resetn), .CE(ce), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .HW_PWRDOWN_N(hw_pd_n), .HW_RESET_N(hw_rst_n), .DMA_REQ_IN(dma_in),
    .DMA_REQ_OUT(dma_out), .CAPTURE_EN(cap_en), .PLAYBACK_EN(ply_en), .MIXER_EN(mix_en),
    .REFERENCE_EN(ref_en), .OUTPUT_MUTE(mute), .FLUSH_CAPTURE(fl_cap),
    .FLUSH_PLAYBACK(fl_ply), .CAPTURE_VALID(cap_vld), .PLAYBACK_ACCEPT(ply_acc),
    .CAL_BUSY(cal_busy), .OFFSET_STORE(ofs_st));

  // 20 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // cycle count; gating watched only once busy has been seen twice, to skip the lag edge
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    prev_busy <= cal_busy;
    if (cal_busy && prev_busy && (dma_out !== 2'b00 || cap_vld !== 1'b0
        || ply_acc !== 1'b0)) bad_gate <= 1'b1;
    if (ofs_st === 1'b1) ofs_seen <= 1'b1;
  end
  // watchdog, about three times the expected run
  initial begin
    #3_000_000;
    num_errors++;
    end_sim();
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // poll until the fixed init answer goes away
  task automatic wait_init();
    int i;
    i = 0;
    do begin
      host.rd(OFS_CTRL, d, r);
      i++;
    end while (d === 32'h80 && i < 200);
  endtask
  // judge one mode-change exit: ran or skipped
  task automatic cal_run(input logic run);
    int i;
    i = 0;
    bad_gate = 1'b0;
    ofs_seen = 1'b0;
    while (cal_busy !== 1'b1 && i < 8) begin
      @(posedge clk_sys);
      i++;
    end
    chk(cal_busy, run);
    if (run) begin
      t0 = cyc;
      host.rd(OFS_STATUS, d, r);
      chk(d[0], 1'b1);
      while (cal_busy === 1'b1 && cyc - t0 < 4000) @(posedge clk_sys);
      chk(cyc - t0 >= 383 * SC - 1 && cyc - t0 <= 384 * SC + 2, 1'b1);
      cycles(3);
      chk({dma_out, cap_vld, ply_acc}, 4'hF);
      chk(bad_gate, 1'b0);
    end else cycles(20);
    chk(ofs_seen, run);
  endtask

  task automatic t_init();
    cycles(4);
    host.rd(OFS_STATUS, d, r);
    chk(d, 32'h80);
    host.wr(OFS_PWRDN, 32'h1, r);
    wait_init();
    chk(d, 32'h1);
    host.rd(OFS_PWRDN, d, r);
    chk(d, 32'h0);
  endtask
  // first exit calibrates, a bare exit does not, the host procedure does
  task automatic t_cal();
    host.wr(OFS_CTRL, 32'h0, r);
    cal_run(1'b1);
    host.wr(OFS_CTRL, 32'h1, r);
    host.wr(OFS_CTRL, 32'h0, r);
    cal_run(1'b0);
    host.wr(OFS_CTRL, 32'h1, r);
    host.wr(OFS_CTRL, 32'h3, r);
    host.wr(OFS_CTRL, 32'h2, r);
    cal_run(1'b1);
  endtask
  // every power-down code, each followed by a timed restore
  task automatic t_modes();
    for (int v = 1; v <= 7; v++) begin
      host.wr(OFS_PWRDN, 32'(v), r);
      cycles(2 * SC + 4);
      chk({cap_en, ply_en, mix_en, fl_cap, fl_ply}, 32'(mode_exp[v][10:6]));
      chk({mute, ref_en}, {1'(v >= 4), 1'b1});
      host.rd(OFS_STATUS, d, r);
      chk({d[9:4], d[3]}, {mode_exp[v][5:0], 1'b1});
      host.wr(OFS_PWRDN, 32'h0, r);
      t0 = cyc;
      cycles(SC + 2);
      host.rd(OFS_STATUS, d, r);
      chk({d[3], d[1]}, 2'b01);
      while (mute === 1'b1 && cyc - t0 < 2000) @(posedge clk_sys);
      chk(cyc - t0 >= 128 * SC - 2 && cyc - t0 <= 130 * SC + 4, 1'b1);
    end
    cycles(2);
    chk({cap_en, ply_en, mix_en, fl_cap, fl_ply, mute}, 6'h38);
    host.rd(OFS_CTRL, d, r);
    chk(d, 32'h2);
  endtask
  // refused outside mode change, accepted inside, exit reinitialises
  task automatic t_tpd();
    host.wr(OFS_CTRL, 32'h6, r);
    cycles(TC + 6);
    host.rd(OFS_STATUS, d, r);
    chk({d[2], ref_en}, 2'b01);
    host.wr(OFS_CTRL, 32'h1, r);
    host.wr(OFS_CTRL, 32'h5, r);
    cycles(TC / 2);
    chk({ref_en, mute}, 2'b11);
    cycles(TC);
    chk({ref_en, cap_en, ply_en, mix_en, fl_cap, fl_ply}, 6'h03);
    host.rd(OFS_STATUS, d, r);
    chk(d[2], 1'b1);
    host.wr(OFS_CTRL, 32'h1, r);
    host.rd(OFS_STATUS, d, r);
    chk(d, 32'h80);
    wait_init();
    chk(d, 32'h1);
    host.wr(OFS_CTRL, 32'h0, r);
    cal_run(1'b1);
  endtask
  // each hardware pin overrides a software state
  task automatic t_hw();
    for (int p = 0; p < 2; p++) begin
      host.wr(OFS_PWRDN, 32'h1, r);
      @(posedge clk_sys);
      {hw_rst_n, hw_pd_n} <= (p == 0) ? 2'b10 : 2'b01;
      cycles(5);
      chk(ref_en, 1'b0);
      {hw_rst_n, hw_pd_n} <= 2'b11;
      cycles(4);
      host.rd(OFS_PWRDN, d, r);
      chk(d, 32'h80);
      wait_init();
      host.rd(OFS_PWRDN, d, r);
      chk(d, 32'h0);
    end
  endtask
  task automatic t_unmapped();
    host.rd(4'hC, d, r);
    chk(d, 32'h0);
    chk(r, 2'b10);
    host.wr(4'hC, 32'h7, r);
    chk(r, 2'b10);
  endtask

  task automatic end_sim();
    $display("tests_run=%0d num_errors=%0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // reset, then the scenarios in order
  initial begin
    mode_exp = '{11'h390, 11'h560, 11'h1C8, 11'h444, 11'h0C2, 11'h444, 11'h0C2};
    {num_errors, tests_run, cyc} = '0;
    {prev_busy, bad_gate, ofs_seen} = '0;
    resetn = 1'b0;
    ce = 1'b1;
    {hw_pd_n, hw_rst_n} = 2'b11;
    dma_in = 2'b11;
    cycles(8);
    resetn <= 1'b1;
    t_init();
    t_cal();
    t_modes();
    t_tpd();
    t_hw();
    t_unmapped();
    end_sim();
  end
endmodule
`default_nettype wire
